// [sle_pkg.sv]
/*
 * Shared constants, types and register map for the sleep and
 * literal-subtract execution block.
 * Assumes a single 100 MHz clock and an AXI4-Lite register bus.
 */
`default_nettype none
package sle_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] SLE_OFF_INSTR  = 8'h00;
  localparam logic [7:0] SLE_OFF_STATUS = 8'h04;
  localparam logic [7:0] SLE_OFF_ACC    = 8'h08;
  localparam logic [7:0] SLE_OFF_WDOG   = 8'h0c;
  localparam logic [7:0] SLE_OFF_CFG    = 8'h10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SLE_ST_CARRY = 8;
  localparam int SLE_ST_ZERO  = 9;
  localparam int SLE_ST_TO_N  = 10;
  localparam int SLE_ST_PD_N  = 11;
  localparam int SLE_ST_SLEEP = 12;
  localparam int SLE_ST_BUSY  = 13;
  localparam int SLE_CFG_PSA  = 0;
  localparam int SLE_CFG_WAKE = 1;
  localparam int SLE_WD_PSC   = 8;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [13:0] SLE_OP_SLEEP  = 14'h0063;
  localparam logic [13:0] SLE_SUB_MASK  = 14'h3e00;
  localparam logic [13:0] SLE_SUB_MATCH = 14'h3c00;

  // ****************************************************************
  // Reset and clear values
  // ****************************************************************
  localparam logic [7:0]  SLE_ACC_RST   = 8'h00;
  localparam logic [13:0] SLE_OP_RST    = 14'h0000;
  localparam logic        SLE_PSA_RST   = 1'b1;
  localparam logic        SLE_TO_N_RST  = 1'b1;
  localparam logic        SLE_PD_N_RST  = 1'b1;
  localparam logic [1:0]  SLE_RESP_OKAY = 2'b00;
  localparam logic [1:0]  SLE_RESP_SLV  = 2'b10;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SLE_PH_IDLE  = 3'b000,
    SLE_PH_Q1    = 3'b001,
    SLE_PH_Q2    = 3'b011,
    SLE_PH_Q3    = 3'b010,
    SLE_PH_Q4    = 3'b110,
    SLE_PH_SLEEP = 3'b100
  } sle_phase_e;

  typedef struct packed {
    logic to_n;
    logic pd_n;
    logic carry;
    logic zero;
  } sle_flags_s;

  typedef struct packed {
    logic [7:0] diff;
    logic       carry;
    logic       zero;
  } sle_alu_s;

endpackage
`default_nettype wire

// [sle_alu.sv]
/*
 * Registered subtractor: literal minus accumulator with borrow and
 * zero flags.
 * Assumes load is a one-cycle strobe from the sequencer.
 */
`timescale 1ns/1ns
`default_nettype none
module sle_alu (
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  input  wire logic            load,
  input  wire logic [7:0]      lit,
  input  wire logic [7:0]      acc,
  output var  sle_pkg::sle_alu_s res
);
  import sle_pkg::*;

  sle_alu_s res_reg;
  sle_alu_s res_next;
  logic [7:0] diff;

  // ****************************************************************
  // Subtract
  // ****************************************************************
  always_comb begin
    res_next = res_reg;
    diff     = lit - acc;
    if (load) begin
      res_next.diff  = diff;
      res_next.carry = (lit >= acc);
      res_next.zero  = (diff == 8'h00);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      res_reg <= '0;
    end else begin
      res_reg <= res_next;
    end
  end

  assign res = res_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_ALU_BORROW: assert property (load && (lit < acc) |=> !res.carry && !res.zero)
    else $error("borrow not flagged");
endmodule
`default_nettype wire

// [sle_core.sv]
/*
 * Execution of the power-down and literal-subtract instructions, with
 * the watchdog counter, its prescaler count and an AXI4-Lite slave.
 * Assumes one clock, each clock edge one quarter-phase.
 */
`timescale 1ns/1ns
`default_nettype none
module sle_core #(
  parameter int ADDR_W = 8,
  parameter int WDOG_W = 8,
  parameter int PSC_W  = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   sleep_mode
);
  import sle_pkg::*;

  if (ADDR_W < 8 || WDOG_W < 1 || WDOG_W > 8 || PSC_W < 1 || PSC_W > 8) begin : g_chk
    $error("sle_core: unsupported parameter values");
  end

  // ****************************************************************
  // Bus state
  // ****************************************************************
  logic              aw_have_reg, aw_have_next;
  logic              w_have_reg,  w_have_next;
  logic [7:0]        waddr_reg,   waddr_next;
  logic [31:0]       wdata_reg,   wdata_next;
  logic [3:0]        wstrb_reg,   wstrb_next;
  logic              bvalid_reg,  bvalid_next;
  logic [1:0]        bresp_reg,   bresp_next;
  logic              rvalid_reg,  rvalid_next;
  logic [1:0]        rresp_reg,   rresp_next;
  logic [31:0]       rdata_reg,   rdata_next;
  logic              wr_fire;
  logic              rd_map;
  logic              wr_map;
  logic [31:0]       rd_word;
  logic [7:0]        raddr;

  // ****************************************************************
  // Core state
  // ****************************************************************
  sle_phase_e        phase_reg,   phase_next;
  logic [13:0]       op_reg,      op_next;
  logic [7:0]        acc_reg,     acc_next;
  sle_flags_s        flags_reg,   flags_next;
  logic [WDOG_W-1:0] wdog_reg,    wdog_next;
  logic [PSC_W-1:0]  psc_reg,     psc_next;
  logic              psa_reg,     psa_next;
  logic              is_sleep;
  logic              is_sub;
  sle_alu_s          alu_res;

  assign is_sleep = (op_reg == SLE_OP_SLEEP);
  assign is_sub   = ((op_reg & SLE_SUB_MASK) == SLE_SUB_MATCH);

  sle_alu u_alu (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .load    (phase_reg == SLE_PH_Q3 && is_sub),
    .lit     (op_reg[7:0]),
    .acc     (acc_reg),
    .res     (alu_res)
  );

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready  = !w_have_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign wr_fire       = aw_have_reg && w_have_reg && !bvalid_reg;
  assign raddr         = {s_axi_araddr[7:2], 2'b00};

  // Read-only registers take writes silently
  assign wr_map = (waddr_reg == SLE_OFF_INSTR) || (waddr_reg == SLE_OFF_STATUS) ||
                  (waddr_reg == SLE_OFF_ACC) || (waddr_reg == SLE_OFF_WDOG) ||
                  (waddr_reg == SLE_OFF_CFG);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_map  = 1'b1;
    case (raddr)
      SLE_OFF_INSTR:  rd_word[13:0] = op_reg;
      SLE_OFF_STATUS: begin
        rd_word[7:0]        = acc_reg;
        rd_word[SLE_ST_CARRY] = flags_reg.carry;
        rd_word[SLE_ST_ZERO]  = flags_reg.zero;
        rd_word[SLE_ST_TO_N]  = flags_reg.to_n;
        rd_word[SLE_ST_PD_N]  = flags_reg.pd_n;
        rd_word[SLE_ST_SLEEP] = (phase_reg == SLE_PH_SLEEP);
        rd_word[SLE_ST_BUSY]  = (phase_reg != SLE_PH_IDLE);
      end
      SLE_OFF_ACC:    rd_word[7:0] = acc_reg;
      SLE_OFF_WDOG: begin
        rd_word[WDOG_W-1:0]                  = wdog_reg;
        rd_word[SLE_WD_PSC+PSC_W-1:SLE_WD_PSC] = psc_reg;
      end
      SLE_OFF_CFG:    rd_word[SLE_CFG_PSA] = psa_reg;
      default:        rd_map = 1'b0;
    endcase
  end

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_map ? SLE_RESP_OKAY : SLE_RESP_SLV;
    end
    if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      waddr_next   = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = rd_map ? SLE_RESP_OKAY : SLE_RESP_SLV;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SLE_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= SLE_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ****************************************************************
  // Quarter-phase sequencer and watchdog
  // ****************************************************************
  always_comb begin
    phase_next = phase_reg;
    op_next    = op_reg;
    acc_next   = acc_reg;
    flags_next = flags_reg;
    psa_next   = psa_reg;
    // Watchdog keeps its own time base, so it runs through sleep
    psc_next   = psc_reg + 1'b1;
    wdog_next  = wdog_reg;
    if (!psa_reg || (&psc_reg)) begin
      wdog_next = wdog_reg + 1'b1;
    end
    if (wr_fire && waddr_reg == SLE_OFF_CFG && wstrb_reg[0]) begin
      psa_next = wdata_reg[SLE_CFG_PSA];
    end
    case (phase_reg)
      SLE_PH_IDLE: begin
        // Accumulator and opcode only change between instructions
        if (wr_fire && waddr_reg == SLE_OFF_INSTR) begin
          op_next[7:0]  = wstrb_reg[0] ? wdata_reg[7:0]  : op_reg[7:0];
          op_next[13:8] = wstrb_reg[1] ? wdata_reg[13:8] : op_reg[13:8];
          phase_next    = SLE_PH_Q1;
        end
        if (wr_fire && waddr_reg == SLE_OFF_ACC && wstrb_reg[0]) begin
          acc_next = wdata_reg[7:0];
        end
      end
      SLE_PH_Q1: phase_next = SLE_PH_Q2;
      SLE_PH_Q2: phase_next = SLE_PH_Q3;
      SLE_PH_Q3: phase_next = SLE_PH_Q4;
      SLE_PH_Q4: begin
        phase_next = SLE_PH_IDLE;
        if (is_sleep) begin
          wdog_next       = '0;
          psc_next        = '0;
          flags_next.to_n = 1'b1;
          flags_next.pd_n = 1'b0;
          phase_next      = SLE_PH_SLEEP;
        end else if (is_sub) begin
          acc_next         = alu_res.diff;
          flags_next.carry = alu_res.carry;
          flags_next.zero  = alu_res.zero;
        end
      end
      SLE_PH_SLEEP: begin
        if (wr_fire && waddr_reg == SLE_OFF_CFG && wstrb_reg[0] && wdata_reg[SLE_CFG_WAKE]) begin
          phase_next = SLE_PH_IDLE;
        end
      end
      default: phase_next = SLE_PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= SLE_PH_IDLE;
      op_reg    <= SLE_OP_RST;
      acc_reg   <= SLE_ACC_RST;
      flags_reg <= '{to_n: SLE_TO_N_RST, pd_n: SLE_PD_N_RST, carry: 1'b0, zero: 1'b0};
      wdog_reg  <= '0;
      psc_reg   <= '0;
      psa_reg   <= SLE_PSA_RST;
    end else begin
      phase_reg <= phase_next;
      op_reg    <= op_next;
      acc_reg   <= acc_next;
      flags_reg <= flags_next;
      wdog_reg  <= wdog_next;
      psc_reg   <= psc_next;
      psa_reg   <= psa_next;
    end
  end

  assign sleep_mode = (phase_reg == SLE_PH_SLEEP);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence seq_sleep_q2_q4;
    phase_reg == SLE_PH_Q2 && is_sleep ##1 phase_reg == SLE_PH_Q3 ##1 phase_reg == SLE_PH_Q4;
  endsequence

  sequence seq_sub_start;
    phase_reg == SLE_PH_Q1 && is_sub;
  endsequence

  AST_SLEEP_WDOG_CLR: assert property (phase_reg == SLE_PH_Q4 && is_sleep |=> wdog_reg == '0 && psc_reg == '0)
    else $error("watchdog not cleared by power-down");
  AST_SLEEP_FLAGS: assert property (phase_reg == SLE_PH_Q4 && is_sleep |=> flags_reg.to_n && !flags_reg.pd_n && $stable(flags_reg.carry) && $stable(flags_reg.zero))
    else $error("power-down status flags wrong");
  AST_SLEEP_ENTER: assert property (seq_sleep_q2_q4 |=> phase_reg == SLE_PH_SLEEP && sleep_mode && $stable(acc_reg))
    else $error("sleep not entered after fourth quarter");
  AST_SLEEP_PSA: assert property (phase_reg == SLE_PH_Q4 && is_sleep |=> psa_reg == $past(psa_reg))
    else $error("prescaler assignment changed by power-down");
  AST_SUB_VALUE: assert property (phase_reg == SLE_PH_Q4 && is_sub |=> acc_reg == 8'(($past(op_reg[7:0]) - $past(acc_reg))))
    else $error("subtract result wrong");
  AST_SUB_ONE_CYCLE: assert property (seq_sub_start |-> ##4 phase_reg == SLE_PH_IDLE)
    else $error("subtract did not finish in one instruction cycle");
  AST_SUB_POS: assert property (phase_reg == SLE_PH_Q4 && is_sub && op_reg[7:0] > acc_reg |=> flags_reg.carry && !flags_reg.zero)
    else $error("positive result flags wrong");
  AST_SUB_EQ: assert property (phase_reg == SLE_PH_Q4 && is_sub && op_reg[7:0] == acc_reg |=> acc_reg == 8'h00 && flags_reg.carry && flags_reg.zero)
    else $error("zero result flags wrong");
  AST_SUB_NEG: assert property (phase_reg == SLE_PH_Q4 && is_sub && op_reg[7:0] < acc_reg |=> !flags_reg.carry && !flags_reg.zero && acc_reg != 8'h00)
    else $error("borrow result flags wrong");
  AST_DECODE: assert property (phase_reg == SLE_PH_IDLE && wr_fire && waddr_reg == SLE_OFF_INSTR && wstrb_reg[1:0] == 2'b11 && wdata_reg[13:0] == SLE_OP_SLEEP |=> phase_reg == SLE_PH_Q1 && is_sleep && !is_sub)
    else $error("power-down opcode not decoded");
endmodule
`default_nettype wire

// [sle_core_test.sv]
/*
 * Self-checking bench for the power-down and literal-subtract block.
 * Assumes sle_pkg and sle_core compiled first; the bench is the AXI4-Lite master.
 */
`timescale 1ns/1ns
`default_nettype none
module sle_core_test;
  import sle_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int LIMIT = 5000;
  logic        clk_sys;
  logic        rstn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        sleep_mode;
  int          n_mismatch;
  int          checks_done;
  int          cycles;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic        exp_c;
  logic        exp_z;
  logic        exp_pd;
  logic [7:0]  exp_acc;

  sle_core i_dut (
    .clk_sys       (clk_sys),
    .rstn          (rstn),
    .s_axi_awaddr  (awaddr),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (4'hf),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_araddr  (araddr),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready),
    .sleep_mode    (sleep_mode)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Hang guard; ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Bus tasks, entered just after a rising edge
  // ****************************************************************
  // Response readies stay high for the whole run, so back-to-back calls never
  // drop and raise them in the same time step
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask

  function automatic logic [31:0] exp_status;
    return {20'h0, exp_pd, 1'b1, exp_z, exp_c, exp_acc};
  endfunction

  // Load the accumulator, run one subtract, check busy then the result
  task automatic do_sub(input logic [7:0] acc, input logic [7:0] k, input logic x);
    logic [8:0] diff;
    axi_write(SLE_OFF_ACC, {24'h0, acc}, rsp);
    axi_write(SLE_OFF_INSTR, {18'h0, 4'hf, 1'b0, x, k}, rsp);
    axi_read(SLE_OFF_STATUS, rd, rsp);
    cmp_bit(rd[SLE_ST_BUSY], 1'b1);
    repeat (4) @(posedge clk_sys);
    diff    = {1'b0, k} - {1'b0, acc};
    exp_acc = diff[7:0];
    exp_c   = ~diff[8];
    exp_z   = (diff[7:0] == 8'h00);
    axi_read(SLE_OFF_STATUS, rd, rsp);
    cmp_word(rd, exp_status());
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  logic [16:0] sub_tab [6] = '{17'h00102, 17'h00202, 17'h10302, 17'h000ff, 17'h1ff00, 17'h0807f};
  logic [13:0] odd_op  [2] = '{14'h3e05, 14'h0064};

  initial begin
    rstn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
    bready = 1'b1; araddr = 8'h00; arvalid = 1'b0; rready = 1'b1;
    n_mismatch = 0; checks_done = 0; cycles = 0;
    exp_c = 1'b0; exp_z = 1'b0; exp_pd = 1'b1; exp_acc = 8'h00;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    axi_read(SLE_OFF_STATUS, rd, rsp);
    cmp_word(rd, 32'h0000_0c00);
    axi_read(SLE_OFF_CFG, rd, rsp);
    cmp_word(rd, 32'h0000_0001);
    // Documented cases plus both ends of the literal range, don't-care bit toggled
    foreach (sub_tab[i]) begin
      do_sub(sub_tab[i][15:8], sub_tab[i][7:0], sub_tab[i][16]);
    end
    // Near-miss opcodes must leave every result alone
    foreach (odd_op[i]) begin
      axi_write(SLE_OFF_INSTR, {18'h0, odd_op[i]}, rsp);
      repeat (6) @(posedge clk_sys);
      axi_read(SLE_OFF_STATUS, rd, rsp);
      cmp_word(rd, exp_status());
      cmp_bit(sleep_mode, 1'b0);
    end
    // Power-down with the prescaler taken away from the watchdog
    axi_write(SLE_OFF_CFG, 32'h0, rsp);
    axi_write(SLE_OFF_INSTR, {18'h0, SLE_OP_SLEEP}, rsp);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_bit(sleep_mode, 1'b0);
    @(posedge clk_sys);
    #1;
    cmp_bit(sleep_mode, 1'b1);
    exp_pd = 1'b0;
    axi_read(SLE_OFF_STATUS, rd, rsp);
    cmp_word(rd & ~32'h2000, exp_status() | 32'h1000);
    // Both counts restart from zero on entry to sleep and step every clock, two edges before the read is taken
    axi_read(SLE_OFF_WDOG, rd, rsp);
    cmp_word(rd, 32'h0000_0202);
    cmp_bit(rd[7:0] <= 8'd3, 1'b1);
    axi_read(SLE_OFF_CFG, rd, rsp);
    cmp_word(rd, 32'h0);
    // A halted core ignores new instructions
    axi_write(SLE_OFF_INSTR, 32'h0000_3c10, rsp);
    repeat (6) @(posedge clk_sys);
    axi_read(SLE_OFF_STATUS, rd, rsp);
    cmp_word(rd & ~32'h2000, exp_status() | 32'h1000);
    axi_write(SLE_OFF_CFG, 32'h3, rsp);
    repeat (2) @(posedge clk_sys);
    cmp_bit(sleep_mode, 1'b0);
    axi_read(SLE_OFF_CFG, rd, rsp);
    cmp_word(rd, 32'h1);
    do_sub(8'h10, 8'h37, 1'b0);
    // Unmapped and read-only places
    axi_write(8'h14, 32'hffff_ffff, rsp);
    cmp_word({30'h0, rsp}, {30'h0, SLE_RESP_SLV});
    axi_read(8'h14, rd, rsp);
    cmp_word({30'h0, rsp}, {30'h0, SLE_RESP_SLV});
    cmp_word(rd, 32'h0);
    axi_write(SLE_OFF_STATUS, 32'h0, rsp);
    cmp_word({30'h0, rsp}, {30'h0, SLE_RESP_OKAY});
    axi_read(SLE_OFF_STATUS, rd, rsp);
    cmp_word(rd, exp_status());
    wrap_up();
  end
endmodule
`default_nettype wire
